/* File: dv/cfu_mem_model.sv */
/*
 Behavioural wide stack memory standing on the far side of the stack port.
 Assumes each request is held until the one-cycle acknowledge that ends it.
*/
`timescale 1ns/1ps
`default_nettype none
module cfu_mem_model (
	input wire logic clk_in,
	input wire logic rstn_in,
	input wire logic slow_in,
	input wire logic req_in,
	input wire logic we_in,
	input wire logic [31:0] addr_in,
	input wire logic [31:0] wdata_in,
	output logic ack_out,
	output logic [31:0] rdata_out
);
	logic [31:0] mem [0:4095];
	logic [31:0] rd_log [0:15];
	int rd_cnt = 0;
	int wait_cnt;
	logic [31:0] last_reg;
	// Outside the acknowledge cycle the read bus shows the inverse of the last answer.
	assign rdata_out = ack_out ? last_reg : ~last_reg;
	always @(posedge clk_in or negedge rstn_in) begin
		if (!rstn_in) begin
			ack_out <= 1'b0;
			wait_cnt <= 0;
			last_reg <= 32'h0;
		end else if (ack_out) begin
			ack_out <= 1'b0;
			wait_cnt <= 0;
		end else if (req_in && wait_cnt >= (slow_in ? 3 : 0)) begin
			ack_out <= 1'b1;
			if (we_in) begin
				mem[addr_in[11:0]] <= wdata_in;
			end else begin
				last_reg <= mem[addr_in[11:0]];
				rd_log[rd_cnt[3:0]] <= addr_in;
				rd_cnt <= rd_cnt + 1;
			end
		end else if (req_in) begin
			wait_cnt <= wait_cnt + 1;
		end
	end
endmodule
`default_nettype wire

/* File: dv/cfu_top_tb.sv */
/*
 Self-checking bench for the subroutine call and return control block.
 Assumes the stack memory model and Avalon-MM register access as the only stimulus.
*/
`timescale 1ns/1ps
`default_nettype none
module cfu_top_tb;
	typedef struct packed {logic [31:0] cmd; logic [31:0] pc; logic [31:0] ac2;} cfu_row_t;
	logic REF_CLK_IN = 1'b0;
	logic RSTN_IN = 1'b0;
	logic [5:0] AVS_ADDRESS_IN = 6'h00;
	logic AVS_READ_IN = 1'b0;
	logic AVS_WRITE_IN = 1'b0;
	logic [31:0] AVS_WRITEDATA_IN = 32'h0;
	logic [3:0] AVS_BYTEENABLE_IN = 4'hF;
	logic [31:0] AVS_READDATA_OUT, MEM_ADDR_OUT, MEM_WDATA_OUT, MEM_RDATA_IN;
	logic AVS_WAITREQUEST_OUT, MEM_REQ_OUT, MEM_WE_OUT, MEM_ACK_IN, EXEC_VALID_OUT;
	logic [15:0] EXEC_OPCODE_OUT;
	logic slow = 1'b0;
	logic [31:0] rd;
	int fails = 0;
	int samples_checked = 0;
	cfu_row_t rows [0:7] = '{'{32'h10, 32'h101, 32'h55}, '{32'h20, 32'h102, 32'h55},
		'{32'h30, 32'h103, 32'h55}, '{32'h40, 32'h104, 32'h55}, '{32'h11, 32'h101, 32'h55},
		'{32'h111, 32'h102, 32'h55}, '{32'h211, 32'h103, 32'h55}, '{32'h22, 32'h200, 32'h102}};
	logic [31:0] blk [0:5] = '{32'h30000, 32'h11, 32'h22, 32'h102, 32'hAAA, 32'h80000102};
	logic [31:0] vcmd [0:2] = '{32'h1016, 32'h16, 32'h2016};
	logic [31:0] vpsr [0:2] = '{32'hA000, 32'h2000, 32'h0};

	always #50 REF_CLK_IN = ~REF_CLK_IN;

	cfu_top cfu_top_i (.REF_CLK_IN(REF_CLK_IN), .RSTN_IN(RSTN_IN), .AVS_ADDRESS_IN(AVS_ADDRESS_IN),
		.AVS_READ_IN(AVS_READ_IN), .AVS_WRITE_IN(AVS_WRITE_IN), .AVS_WRITEDATA_IN(AVS_WRITEDATA_IN),
		.AVS_BYTEENABLE_IN(AVS_BYTEENABLE_IN), .AVS_READDATA_OUT(AVS_READDATA_OUT),
		.AVS_WAITREQUEST_OUT(AVS_WAITREQUEST_OUT), .MEM_REQ_OUT(MEM_REQ_OUT), .MEM_WE_OUT(MEM_WE_OUT),
		.MEM_ADDR_OUT(MEM_ADDR_OUT), .MEM_WDATA_OUT(MEM_WDATA_OUT), .MEM_ACK_IN(MEM_ACK_IN),
		.MEM_RDATA_IN(MEM_RDATA_IN), .EXEC_VALID_OUT(EXEC_VALID_OUT), .EXEC_OPCODE_OUT(EXEC_OPCODE_OUT));

	cfu_mem_model cfu_mem_model_i (.clk_in(REF_CLK_IN), .rstn_in(RSTN_IN), .slow_in(slow),
		.req_in(MEM_REQ_OUT), .we_in(MEM_WE_OUT), .addr_in(MEM_ADDR_OUT), .wdata_in(MEM_WDATA_OUT),
		.ack_out(MEM_ACK_IN), .rdata_out(MEM_RDATA_IN));

	task automatic stop_test();
		$display("comparisons %0d mismatches %0d", samples_checked, fails);
		if (fails == 0 && samples_checked > 0) begin
			$display("== PASSED ==");
		end else begin
			$display("== FAILED ==");
		end
		$finish;
	endtask

	task automatic check(input logic [31:0] seen, input logic [31:0] exp);
		samples_checked++;
		if (seen !== exp) begin
			fails++;
			$display("ERROR at %0t seen %h expected %h", $time, seen, exp);
		end
	endtask

	task automatic bus(input logic we, input logic [5:0] a, input logic [31:0] d);
		int n = 0;
		@(posedge REF_CLK_IN);
		AVS_ADDRESS_IN <= a;
		AVS_WRITEDATA_IN <= d;
		AVS_WRITE_IN <= we;
		AVS_READ_IN <= ~we;
		do begin
			@(posedge REF_CLK_IN);
			n++;
		end while (AVS_WAITREQUEST_OUT !== 1'b0 && n < 500);
		rd = AVS_READDATA_OUT;
		AVS_WRITE_IN <= 1'b0;
		AVS_READ_IN <= 1'b0;
		if (n >= 500) begin
			check(32'h1, 32'h0);
			stop_test();
		end
	endtask

	task automatic wr(input logic [5:0] a, input logic [31:0] d);
		bus(1'b1, a, d);
	endtask

	task automatic rchk(input logic [5:0] a, input logic [31:0] e);
		bus(1'b0, a, 32'h0);
		check(rd, e);
	endtask

	task automatic run(input logic [31:0] c);
		int n = 0;
		wr(cfu_pkg::OFS_CMD, c);
		do begin
			bus(1'b0, cfu_pkg::OFS_STAT, 32'h0);
			n++;
		end while (rd[31] !== 1'b0 && n < 200);
		if (n >= 200) begin
			check(32'h1, 32'h0);
			stop_test();
		end
	endtask

	initial begin
		repeat (20) @(posedge REF_CLK_IN);
		check({31'h0, AVS_WAITREQUEST_OUT}, 32'h1);
		check({31'h0, MEM_REQ_OUT}, 32'h0);
		RSTN_IN <= 1'b1;
		rchk(cfu_pkg::OFS_PC, 32'h0);
		rchk(cfu_pkg::OFS_SP, 32'h0);
		rchk(cfu_pkg::OFS_PSR, 32'h0);
		wr(6'h34, 32'hFFFFFFFF);
		rchk(6'h34, 32'h0);
		foreach (rows[i]) begin
			wr(cfu_pkg::OFS_PC, 32'h100);
			wr(cfu_pkg::OFS_AC2, 32'h55);
			wr(cfu_pkg::OFS_EA, 32'h200);
			run(rows[i].cmd);
			rchk(cfu_pkg::OFS_PC, rows[i].pc);
			rchk(cfu_pkg::OFS_AC2, rows[i].ac2);
		end
		wr(cfu_pkg::OFS_SP, 32'h1000);
		wr(cfu_pkg::OFS_PC, 32'h100);
		run(32'h33);
		rchk(cfu_pkg::OFS_PC, 32'h200);
		rchk(cfu_pkg::OFS_SP, 32'h1002);
		run(32'h14);
		rchk(cfu_pkg::OFS_PC, 32'h103);
		rchk(cfu_pkg::OFS_SP, 32'h1000);
		wr(cfu_pkg::OFS_EA, 32'h300);
		wr(cfu_pkg::OFS_ARG, 32'h3);
		run(32'h45);
		rchk(cfu_pkg::OFS_PC, 32'h300);
		rchk(cfu_pkg::OFS_SP, 32'h1002);
		slow <= 1'b1;
		wr(cfu_pkg::OFS_SP, 32'h1000);
		wr(cfu_pkg::OFS_WFP, 32'hAAA);
		wr(cfu_pkg::OFS_PSR, 32'h3);
		wr(cfu_pkg::OFS_AC0, 32'h11);
		wr(cfu_pkg::OFS_AC1, 32'h22);
		wr(cfu_pkg::OFS_AC3, 32'h33);
		wr(cfu_pkg::OFS_CRY, 32'h1);
		wr(cfu_pkg::OFS_PC, 32'h100);
		wr(cfu_pkg::OFS_EA, 32'h200);
		wr(cfu_pkg::OFS_ARG, 32'h1);
		// The caller jumps first and the subroutine saves as its first step.
		run(32'h22);
		run(32'h1016);
		for (int i = 0; i < 6; i++) begin
			check(cfu_mem_model_i.mem[2 + 2 * i], blk[i]);
		end
		rchk(cfu_pkg::OFS_PSR, 32'h8003);
		rchk(cfu_pkg::OFS_WFP, 32'h100C);
		rchk(cfu_pkg::OFS_SP, 32'h100E);
		wr(cfu_pkg::OFS_AC0, 32'h99);
		wr(cfu_pkg::OFS_CRY, 32'h0);
		cfu_mem_model_i.rd_cnt = 0;
		run(32'h17);
		rchk(cfu_pkg::OFS_PC, 32'h102);
		rchk(cfu_pkg::OFS_AC0, 32'h11);
		rchk(cfu_pkg::OFS_CRY, 32'h1);
		rchk(cfu_pkg::OFS_WFP, 32'hAAA);
		rchk(cfu_pkg::OFS_SP, 32'h1000);
		check(cfu_mem_model_i.rd_log[0], 32'h100C);
		check(cfu_mem_model_i.rd_log[5], 32'h1002);
		slow <= 1'b0;
		for (int i = 0; i < 3; i++) begin
			wr(cfu_pkg::OFS_PSR, 32'h2000);
			wr(cfu_pkg::OFS_SP, 32'h1000);
			wr(cfu_pkg::OFS_ARG, 32'h0);
			run(vcmd[i]);
			rchk(cfu_pkg::OFS_PSR, vpsr[i]);
			rchk(cfu_pkg::OFS_SP, 32'h100C);
		end
		// The original opcode 1234 is written to AC0 by the bench after the breakpoint command runs, ahead of the pop block execute.
		wr(cfu_pkg::OFS_SP, 32'h1000);
		wr(cfu_pkg::OFS_PC, 32'h400);
		wr(cfu_pkg::OFS_EA, 32'h800);
		wr(cfu_pkg::OFS_PSR, 32'h0);
		wr(cfu_pkg::OFS_CRY, 32'h0);
		run(32'h18);
		rchk(cfu_pkg::OFS_SP, 32'h100C);
		rchk(cfu_pkg::OFS_PC, 32'h800);
		check(cfu_mem_model_i.mem[12'h00A], 32'h33);
		check(cfu_mem_model_i.mem[12'h00C], 32'h400);
		wr(cfu_pkg::OFS_AC0, 32'h1234);
		run(32'h1A);
		rchk(cfu_pkg::OFS_SP, 32'h1000);
		rchk(cfu_pkg::OFS_PC, 32'h400);
		check({16'h0, EXEC_OPCODE_OUT}, 32'h1234);
		check({31'h0, EXEC_VALID_OUT}, 32'h1);
		run(32'h1C);
		rchk(cfu_pkg::OFS_PSR, 32'h4000);
		rchk(cfu_pkg::OFS_SP, 32'h1002);
		check({16'h0, cfu_mem_model_i.mem[12'h002][15:0]}, 32'h1234);
		run(32'h18);
		rchk(cfu_pkg::OFS_PSR, 32'h0);
		rchk(cfu_pkg::OFS_SP, 32'h1000);
		check({16'h0, EXEC_OPCODE_OUT}, 32'h1234);
		check({31'h0, EXEC_VALID_OUT}, 32'h1);
		run(32'h10);
		check({31'h0, EXEC_VALID_OUT}, 32'h0);
		wr(cfu_pkg::OFS_PC, 32'h600);
		run(32'h18);
		run(32'h1B);
		rchk(cfu_pkg::OFS_PC, 32'h600);
		rchk(cfu_pkg::OFS_SP, 32'h1000);
		check({31'h0, EXEC_VALID_OUT}, 32'h0);
		wr(cfu_pkg::OFS_SP, 32'h1000);
		wr(cfu_pkg::OFS_PC, 32'h700);
		wr(cfu_pkg::OFS_EA, 32'h900);
		wr(cfu_pkg::OFS_AC3, 32'h77);
		wr(cfu_pkg::OFS_CRY, 32'h0);
		run(32'h29);
		rchk(cfu_pkg::OFS_PC, 32'h900);
		rchk(cfu_pkg::OFS_SP, 32'h100C);
		check(cfu_mem_model_i.mem[12'h00A], 32'h77);
		check(cfu_mem_model_i.mem[12'h00C], 32'h702);
		run(32'h1B);
		rchk(cfu_pkg::OFS_PC, 32'h702);
		rchk(cfu_pkg::OFS_SP, 32'h1000);
		wr(cfu_pkg::OFS_PC, 32'h500);
		wr(cfu_pkg::OFS_EA, 32'h1234);
		run(32'h2D);
		check({31'h0, rd[29]}, 32'h1);
		rchk(cfu_pkg::OFS_PC, 32'h500);
		run(32'h1E);
		check({31'h0, rd[29]}, 32'h0);
		rchk(cfu_pkg::OFS_PC, 32'h502);
		stop_test();
	end
endmodule
`default_nettype wire

/* File: hw/cfu_pkg.sv */
/*
 Shared constants and types for the subroutine call and return control block.
 Assumes a 32-bit word-aligned register bus and a wide stack that steps two addresses per doubleword.
*/
package cfu_pkg;
	localparam logic [5:0] OFS_CMD = 6'h00;
	localparam logic [5:0] OFS_EA = 6'h04;
	localparam logic [5:0] OFS_ARG = 6'h08;
	localparam logic [5:0] OFS_PC = 6'h0C;
	localparam logic [5:0] OFS_AC0 = 6'h10;
	localparam logic [5:0] OFS_AC1 = 6'h14;
	localparam logic [5:0] OFS_AC2 = 6'h18;
	localparam logic [5:0] OFS_AC3 = 6'h1C;
	localparam logic [5:0] OFS_PSR = 6'h20;
	localparam logic [5:0] OFS_WFP = 6'h24;
	localparam logic [5:0] OFS_SP = 6'h28;
	localparam logic [5:0] OFS_CRY = 6'h2C;
	localparam logic [5:0] OFS_STAT = 6'h30;
	localparam logic [3:0] OP_NEXT = 4'h0;
	localparam logic [3:0] OP_QSRCH = 4'h1;
	localparam logic [3:0] OP_JSR = 4'h2;
	localparam logic [3:0] OP_PSHJ = 4'h3;
	localparam logic [3:0] OP_POPJ = 4'h4;
	localparam logic [3:0] OP_CALL = 4'h5;
	localparam logic [3:0] OP_SAVE = 4'h6;
	localparam logic [3:0] OP_WIDE_RETURN = 4'h7;
	localparam logic [3:0] OP_BREAKPOINT_OP = 4'h8;
	localparam logic [3:0] OP_XOP = 4'h9;
	localparam logic [3:0] OP_PBX = 4'hA;
	localparam logic [3:0] OP_POPB = 4'hB;
	localparam logic [3:0] OP_INTR = 4'hC;
	localparam logic [3:0] OP_EDIT = 4'hD;
	localparam logic [3:0] OP_END_EDIT_OP = 4'hE;
	localparam int CMD_LEN_LSB = 4;
	localparam int CMD_OUT_LSB = 8;
	localparam int CMD_SET_POS = 12;
	localparam int CMD_SPEC_POS = 13;
	localparam int PSR_OVK_POS = 15;
	localparam int PSR_INTERRUPTED_EXECUTE_FLAG_POS = 14;
	localparam int PSR_TRAP_POS = 13;
	localparam logic [2:0] BLK_LAST = 3'h5;
	localparam logic [31:0] DW_STEP = 32'h00000002;
	localparam logic [31:0] BLK_SPAN = 32'h0000000C;
	localparam logic [31:0] WORD_RST = 32'h00000000;
	localparam logic [15:0] PSR_RST = 16'h0000;
	typedef struct packed {
		logic req;
		logic we;
		logic [31:0] addr;
		logic [31:0] wdata;
	} cfu_mem_req_t;
	localparam cfu_mem_req_t MEM_IDLE = '{1'b0, 1'b0, 32'h00000000, 32'h00000000};
	typedef enum logic {ST_IDLE, ST_STACK} cfu_state_t;
endpackage

/* File: hw/cfu_stack_port.sv */
/*
 One doubleword push or pop on the wide stack memory.
 Holds each request until the memory answers it with a one-cycle acknowledge.
*/
`timescale 1ns/1ps
`default_nettype none
module cfu_stack_port (
	input wire logic clk_in,
	input wire logic rstn_in,
	input wire logic start_in,
	input wire logic push_in,
	input wire logic [31:0] sp_in,
	input wire logic [31:0] wdata_in,
	input wire logic ack_in,
	input wire logic [31:0] rdata_in,
	output var cfu_pkg::cfu_mem_req_t mem_out,
	output logic done_out,
	output logic [31:0] rdata_out
);
	cfu_pkg::cfu_mem_req_t mem_reg;
	logic done_reg;
	logic [31:0] rd_reg;

	always_ff @(posedge clk_in or negedge rstn_in) begin
		if (!rstn_in) begin
			mem_reg <= cfu_pkg::MEM_IDLE;
			done_reg <= 1'b0;
			rd_reg <= cfu_pkg::WORD_RST;
		end else begin
			done_reg <= 1'b0;
			if (mem_reg.req) begin
				if (ack_in) begin
					mem_reg.req <= 1'b0;
					done_reg <= 1'b1;
					rd_reg <= rdata_in;
				end
			end else if (start_in) begin
				mem_reg.req <= 1'b1;
				mem_reg.we <= push_in;
				mem_reg.addr <= push_in ? sp_in + cfu_pkg::DW_STEP : sp_in;
				mem_reg.wdata <= wdata_in;
			end
		end
	end

	assign mem_out = mem_reg;
	assign done_out = done_reg;
	assign rdata_out = rd_reg;
endmodule
`default_nettype wire

/* File: hw/cfu_top.sv */
/*
 Subroutine call and return control with its wide return block sequencing.
 Assumes an Avalon-MM master issues one command at a time and a stack memory answers.
*/
`timescale 1ns/1ps
`default_nettype none
module cfu_top (
	input wire logic REF_CLK_IN,
	input wire logic RSTN_IN,
	input wire logic [5:0] AVS_ADDRESS_IN,
	input wire logic AVS_READ_IN,
	input wire logic AVS_WRITE_IN,
	input wire logic [31:0] AVS_WRITEDATA_IN,
	input wire logic [3:0] AVS_BYTEENABLE_IN,
	output logic [31:0] AVS_READDATA_OUT,
	output logic AVS_WAITREQUEST_OUT,
	output logic MEM_REQ_OUT,
	output logic MEM_WE_OUT,
	output logic [31:0] MEM_ADDR_OUT,
	output logic [31:0] MEM_WDATA_OUT,
	input wire logic MEM_ACK_IN,
	input wire logic [31:0] MEM_RDATA_IN,
	output logic EXEC_VALID_OUT,
	output logic [15:0] EXEC_OPCODE_OUT
);
	function automatic logic [31:0] be_merge(input logic [31:0] o, input logic [31:0] n, input logic [3:0] be);
		logic [31:0] r;
		r = o;
		for (int i = 0; i < 4; i++) begin
			if (be[i]) begin
				r[i*8 +: 8] = n[i*8 +: 8];
			end
		end
		return r;
	endfunction

	cfu_pkg::cfu_state_t st_reg;
	cfu_pkg::cfu_mem_req_t mem;
	logic ack_reg, wait_reg, go_reg, pend_reg, dir_reg, blk_reg, cry_reg, subst_reg, edit_reg;
	logic [31:0] rdata_reg, rd_next, cmd_reg, ea_reg, arg_reg, pc_reg, wfp_reg, sp_reg, ret_reg;
	logic [31:0] edit_ret_reg, edit_ptr_reg, port_rdata, nxt_pc, len32, outc32, locals, wmerge, ret_pc;
	logic [31:0] ac_reg [0:3];
	logic [31:0] blk_mem [0:5];
	logic [15:0] psr_reg, argc_reg, subst_op_reg;
	logic [3:0] op;
	logic [2:0] idx_reg, last_reg, cnt_reg;
	logic acc, busy, wr, start, port_start, port_done, pdone, last, st_push, st_pop, st_blk;
	localparam int CMD_LEN_LSB_P = cfu_pkg::CMD_LEN_LSB;
	localparam int CMD_OUT_LSB_P = cfu_pkg::CMD_OUT_LSB;

	assign busy = (st_reg != cfu_pkg::ST_IDLE) || go_reg;
	assign acc = (AVS_READ_IN || AVS_WRITE_IN) && !ack_reg && (AVS_READ_IN || !busy);
	assign wr = ack_reg && AVS_WRITE_IN;
	assign wmerge = be_merge(rd_next, AVS_WRITEDATA_IN, AVS_BYTEENABLE_IN);
	assign op = cmd_reg[3:0];
	assign len32 = {29'h0, cmd_reg[CMD_LEN_LSB_P +: 3]};
	assign outc32 = {30'h0, cmd_reg[CMD_OUT_LSB_P +: 2]};
	assign nxt_pc = pc_reg + len32;
	assign locals = {15'h0, arg_reg[15:0], 1'b0};
	assign start = go_reg;
	assign pdone = (st_reg == cfu_pkg::ST_STACK) && port_done;
	assign last = idx_reg == last_reg;
	assign port_start = (st_reg == cfu_pkg::ST_STACK) && !pend_reg;
	assign ret_pc = op == cfu_pkg::OP_BREAKPOINT_OP ? pc_reg : (op == cfu_pkg::OP_XOP ? nxt_pc : ret_reg);

	always_comb begin
		st_blk = op == cfu_pkg::OP_SAVE || op == cfu_pkg::OP_XOP || op == cfu_pkg::OP_WIDE_RETURN
			|| op == cfu_pkg::OP_PBX || op == cfu_pkg::OP_POPB
			|| (op == cfu_pkg::OP_BREAKPOINT_OP && !psr_reg[cfu_pkg::PSR_INTERRUPTED_EXECUTE_FLAG_POS]);
		st_push = op == cfu_pkg::OP_PSHJ || op == cfu_pkg::OP_CALL || op == cfu_pkg::OP_SAVE
			|| op == cfu_pkg::OP_XOP || (op == cfu_pkg::OP_INTR && subst_reg)
			|| (op == cfu_pkg::OP_BREAKPOINT_OP && !psr_reg[cfu_pkg::PSR_INTERRUPTED_EXECUTE_FLAG_POS]);
		st_pop = op == cfu_pkg::OP_POPJ || op == cfu_pkg::OP_WIDE_RETURN || op == cfu_pkg::OP_PBX
			|| op == cfu_pkg::OP_POPB || (op == cfu_pkg::OP_BREAKPOINT_OP && psr_reg[cfu_pkg::PSR_INTERRUPTED_EXECUTE_FLAG_POS]);
	end

	always_comb begin
		rd_next = cfu_pkg::WORD_RST;
		unique case (AVS_ADDRESS_IN)
			cfu_pkg::OFS_CMD: rd_next = cmd_reg;
			cfu_pkg::OFS_EA: rd_next = ea_reg;
			cfu_pkg::OFS_ARG: rd_next = arg_reg;
			cfu_pkg::OFS_PC: rd_next = pc_reg;
			cfu_pkg::OFS_AC0: rd_next = ac_reg[0];
			cfu_pkg::OFS_AC1: rd_next = ac_reg[1];
			cfu_pkg::OFS_AC2: rd_next = ac_reg[2];
			cfu_pkg::OFS_AC3: rd_next = ac_reg[3];
			cfu_pkg::OFS_PSR: rd_next = {16'h0, psr_reg};
			cfu_pkg::OFS_WFP: rd_next = wfp_reg;
			cfu_pkg::OFS_SP: rd_next = sp_reg;
			cfu_pkg::OFS_CRY: rd_next = {31'h0, cry_reg};
			cfu_pkg::OFS_STAT: rd_next = {busy, subst_reg, edit_reg, 13'h0, subst_op_reg};
			default: rd_next = cfu_pkg::WORD_RST;
		endcase
	end

	// Bus slave: one wait cycle, more for a write while busy, then waitrequest low for exactly one cycle.
	always_ff @(posedge REF_CLK_IN or negedge RSTN_IN) begin
		if (!RSTN_IN) begin
			ack_reg <= 1'b0;
			wait_reg <= 1'b1;
			rdata_reg <= cfu_pkg::WORD_RST;
		end else begin
			ack_reg <= acc;
			wait_reg <= !acc;
			if (acc) begin
				rdata_reg <= rd_next;
			end
		end
	end

	always_ff @(posedge REF_CLK_IN or negedge RSTN_IN) begin
		if (!RSTN_IN) begin
			cmd_reg <= cfu_pkg::WORD_RST;
			go_reg <= 1'b0;
		end else begin
			go_reg <= wr && AVS_ADDRESS_IN == cfu_pkg::OFS_CMD;
			if (wr && AVS_ADDRESS_IN == cfu_pkg::OFS_CMD) begin
				cmd_reg <= wmerge;
			end
		end
	end

	// Stack sequencer: single doubleword or a whole return block.
	always_ff @(posedge REF_CLK_IN or negedge RSTN_IN) begin
		if (!RSTN_IN) begin
			st_reg <= cfu_pkg::ST_IDLE;
			idx_reg <= 3'h0;
			last_reg <= 3'h0;
			dir_reg <= 1'b0;
			blk_reg <= 1'b0;
			pend_reg <= 1'b0;
			cnt_reg <= 3'h0;
		end else begin
			if (start && (st_push || st_pop)) begin
				st_reg <= cfu_pkg::ST_STACK;
				idx_reg <= 3'h0;
				last_reg <= st_blk ? cfu_pkg::BLK_LAST : 3'h0;
				dir_reg <= st_push;
				blk_reg <= st_blk;
				cnt_reg <= 3'h0;
			end else if (pdone) begin
				pend_reg <= 1'b0;
				cnt_reg <= cnt_reg + 3'h1;
				if (last) begin
					st_reg <= cfu_pkg::ST_IDLE;
				end else begin
					idx_reg <= idx_reg + 3'h1;
				end
			end else if (port_start) begin
				pend_reg <= 1'b1;
			end
		end
	end

	// Push image captured at command start, so later status changes do not leak in.
	always_ff @(posedge REF_CLK_IN or negedge RSTN_IN) begin
		if (!RSTN_IN) begin
			for (int i = 0; i < 6; i++) begin
				blk_mem[i] <= cfu_pkg::WORD_RST;
			end
		end else if (start) begin
			unique case (op)
				cfu_pkg::OP_PSHJ: blk_mem[0] <= nxt_pc;
				cfu_pkg::OP_CALL: blk_mem[0] <= {16'h0, arg_reg[15:0]};
				cfu_pkg::OP_INTR: blk_mem[0] <= {16'h0, subst_op_reg};
				cfu_pkg::OP_SAVE, cfu_pkg::OP_BREAKPOINT_OP, cfu_pkg::OP_XOP: begin
					blk_mem[0] <= {psr_reg, op == cfu_pkg::OP_SAVE ? argc_reg : 16'h0};
					blk_mem[1] <= ac_reg[0];
					blk_mem[2] <= ac_reg[1];
					blk_mem[3] <= ac_reg[2];
					blk_mem[4] <= op == cfu_pkg::OP_SAVE ? wfp_reg : ac_reg[3];
					blk_mem[5] <= {cry_reg, ret_pc[30:0]};
				end
				default: blk_mem[0] <= blk_mem[0];
			endcase
		end
	end

	always_ff @(posedge REF_CLK_IN or negedge RSTN_IN) begin
		if (!RSTN_IN) begin
			for (int i = 0; i < 4; i++) begin
				ac_reg[i] <= cfu_pkg::WORD_RST;
			end
			pc_reg <= cfu_pkg::WORD_RST;
			ea_reg <= cfu_pkg::WORD_RST;
			arg_reg <= cfu_pkg::WORD_RST;
			wfp_reg <= cfu_pkg::WORD_RST;
			sp_reg <= cfu_pkg::WORD_RST;
			ret_reg <= cfu_pkg::WORD_RST;
			edit_ret_reg <= cfu_pkg::WORD_RST;
			edit_ptr_reg <= cfu_pkg::WORD_RST;
			psr_reg <= cfu_pkg::PSR_RST;
			argc_reg <= 16'h0000;
			subst_op_reg <= 16'h0000;
			cry_reg <= 1'b0;
			subst_reg <= 1'b0;
			edit_reg <= 1'b0;
		end else if (wr) begin
			unique case (AVS_ADDRESS_IN)
				cfu_pkg::OFS_EA: ea_reg <= wmerge;
				cfu_pkg::OFS_ARG: arg_reg <= wmerge;
				cfu_pkg::OFS_PC: pc_reg <= wmerge;
				cfu_pkg::OFS_AC0: ac_reg[0] <= wmerge;
				cfu_pkg::OFS_AC1: ac_reg[1] <= wmerge;
				cfu_pkg::OFS_AC2: ac_reg[2] <= wmerge;
				cfu_pkg::OFS_AC3: ac_reg[3] <= wmerge;
				cfu_pkg::OFS_PSR: psr_reg <= wmerge[15:0];
				cfu_pkg::OFS_WFP: wfp_reg <= wmerge;
				cfu_pkg::OFS_SP: sp_reg <= wmerge;
				cfu_pkg::OFS_CRY: cry_reg <= wmerge[0];
				default: cry_reg <= cry_reg;
			endcase
		end else if (start) begin
			unique case (op)
				cfu_pkg::OP_NEXT: begin
					pc_reg <= nxt_pc;
					subst_reg <= 1'b0;
				end
				cfu_pkg::OP_QSRCH: pc_reg <= nxt_pc + outc32;
				cfu_pkg::OP_JSR: begin
					ac_reg[2] <= nxt_pc;
					ret_reg <= nxt_pc;
					argc_reg <= 16'h0000;
					pc_reg <= {pc_reg[31:28], ea_reg[27:0]};
				end
				cfu_pkg::OP_PSHJ: pc_reg <= {pc_reg[31:28], ea_reg[27:0]};
				cfu_pkg::OP_CALL: begin
					argc_reg <= arg_reg[15:0];
					ret_reg <= nxt_pc;
					pc_reg <= {1'b0, ea_reg[30:0]};
				end
				cfu_pkg::OP_SAVE: begin
					wfp_reg <= sp_reg + cfu_pkg::BLK_SPAN;
					psr_reg[cfu_pkg::PSR_OVK_POS] <= cmd_reg[cfu_pkg::CMD_SET_POS];
					if (cmd_reg[cfu_pkg::CMD_SPEC_POS]) begin
						psr_reg[cfu_pkg::PSR_TRAP_POS] <= 1'b0;
					end
				end
				cfu_pkg::OP_WIDE_RETURN: sp_reg <= wfp_reg;
				cfu_pkg::OP_BREAKPOINT_OP: begin
					if (psr_reg[cfu_pkg::PSR_INTERRUPTED_EXECUTE_FLAG_POS]) begin
						psr_reg[cfu_pkg::PSR_INTERRUPTED_EXECUTE_FLAG_POS] <= 1'b0;
					end else begin
						pc_reg <= ea_reg;
					end
				end
				cfu_pkg::OP_XOP: pc_reg <= ea_reg;
				cfu_pkg::OP_PBX: subst_op_reg <= ac_reg[0][15:0];
				cfu_pkg::OP_POPB: cry_reg <= cry_reg;
				cfu_pkg::OP_INTR: begin
					if (subst_reg) begin
						psr_reg[cfu_pkg::PSR_INTERRUPTED_EXECUTE_FLAG_POS] <= 1'b1;
						subst_reg <= 1'b0;
					end
				end
				cfu_pkg::OP_EDIT: begin
					edit_ret_reg <= nxt_pc;
					edit_ptr_reg <= ea_reg;
					edit_reg <= 1'b1;
				end
				cfu_pkg::OP_END_EDIT_OP: begin
					pc_reg <= edit_ret_reg;
					edit_reg <= 1'b0;
				end
				default: pc_reg <= pc_reg;
			endcase
		end else if (pdone) begin
			if (dir_reg) begin
				sp_reg <= (last && op == cfu_pkg::OP_SAVE) ? sp_reg + cfu_pkg::DW_STEP + locals
					: sp_reg + cfu_pkg::DW_STEP;
			end else begin
				sp_reg <= sp_reg - cfu_pkg::DW_STEP;
				if (blk_reg) begin
					unique case (idx_reg)
						3'h0: begin
							cry_reg <= port_rdata[31];
							pc_reg <= {1'b0, port_rdata[30:0]};
						end
						3'h1: begin
							if (op == cfu_pkg::OP_WIDE_RETURN) begin
								wfp_reg <= port_rdata;
							end else begin
								ac_reg[3] <= port_rdata;
							end
						end
						3'h2: ac_reg[2] <= port_rdata;
						3'h3: ac_reg[1] <= port_rdata;
						3'h4: ac_reg[0] <= port_rdata;
						3'h5: psr_reg <= port_rdata[31:16];
						default: psr_reg <= psr_reg;
					endcase
					if (last && op == cfu_pkg::OP_PBX) begin
						subst_reg <= 1'b1;
					end
				end else if (op == cfu_pkg::OP_POPJ) begin
					pc_reg <= port_rdata;
				end else begin
					subst_op_reg <= port_rdata[15:0];
					subst_reg <= 1'b1;
				end
			end
		end
	end

	cfu_stack_port u_port (
		.clk_in(REF_CLK_IN),
		.rstn_in(RSTN_IN),
		.start_in(port_start),
		.push_in(dir_reg),
		.sp_in(sp_reg),
		.wdata_in(blk_mem[idx_reg]),
		.ack_in(MEM_ACK_IN),
		.rdata_in(MEM_RDATA_IN),
		.mem_out(mem),
		.done_out(port_done),
		.rdata_out(port_rdata)
	);

	assign AVS_READDATA_OUT = rdata_reg;
	assign AVS_WAITREQUEST_OUT = wait_reg;
	assign MEM_REQ_OUT = mem.req;
	assign MEM_WE_OUT = mem.we;
	assign MEM_ADDR_OUT = mem.addr;
	assign MEM_WDATA_OUT = mem.wdata;
	assign EXEC_VALID_OUT = subst_reg;
	assign EXEC_OPCODE_OUT = subst_op_reg;

	default clocking cb @(posedge REF_CLK_IN);
	endclocking
	default disable iff (!RSTN_IN);

	chk_pc_advance: assert property (
		start && op == cfu_pkg::OP_NEXT |=> pc_reg == $past(nxt_pc)) else $error("pc did not advance by length");
	chk_qsearch_skip: assert property (
		start && op == cfu_pkg::OP_QSRCH |=> pc_reg == $past(pc_reg) + $past(len32) + $past(outc32))
		else $error("queue search resumed at wrong word");
	chk_jsr_link: assert property (
		start && op == cfu_pkg::OP_JSR |=> ac_reg[2] == $past(nxt_pc) && pc_reg[31:28] == $past(pc_reg[31:28]))
		else $error("jump to subroutine link or segment wrong");
	chk_block_six: assert property (
		pdone && last && blk_reg |-> cnt_reg == 3'h5) else $error("return block was not six doublewords");
	chk_first_word: assert property (
		mem.req && mem.we && blk_reg && idx_reg == 3'h0 |-> mem.wdata[15:0] == (op == cfu_pkg::OP_SAVE ? argc_reg : 16'h0))
		else $error("first block word argument count wrong");
	chk_sixth_word: assert property (
		mem.req && mem.we && blk_reg && idx_reg == 3'h5 |-> mem.wdata[31] == cry_reg)
		else $error("sixth block word carry wrong");
	chk_pop_order: assert property (
		pdone && !dir_reg && blk_reg && idx_reg == 3'h0 |=> pc_reg == {1'b0, $past(port_rdata[30:0])})
		else $error("first popped word did not restore pc");
	chk_pbx_subst: assert property (
		start && op == cfu_pkg::OP_PBX |=> subst_op_reg == $past(ac_reg[0][15:0]) && st_reg == cfu_pkg::ST_STACK)
		else $error("pop block execute did not keep opcode");
	chk_interrupted_execute_flag_set: assert property (
		start && op == cfu_pkg::OP_INTR && subst_reg |=> psr_reg[cfu_pkg::PSR_INTERRUPTED_EXECUTE_FLAG_POS] && dir_reg && !subst_reg)
		else $error("interrupted execute flag not set");
	chk_edit_pc: assert property (
		start && op == cfu_pkg::OP_EDIT |=> pc_reg == $past(pc_reg) && edit_reg)
		else $error("wide edit altered the program counter");
endmodule
`default_nettype wire
